// ---- src/ccpsr_pkg.sv ----
// constants and types for the clock chip pll shadow register block
package ccpsr_pkg;

  // register bus address width
  localparam int ADDR_W = 16;

  // register byte offsets
  localparam logic [15:0] CSR_OFS      = 16'h8110;  // control/status
  localparam logic [15:0] OUTCTL_OFS   = 16'h8114;  // output control
  localparam logic [15:0] FREQ_OFS     = 16'h8128;  // freq / loop filter
  localparam logic [15:0] DIV_OFS      = 16'h812c;  // ref divider / lock
  localparam logic [15:0] IRQ_STAT_OFS = 16'h8140;  // sticky events
  localparam logic [15:0] IRQ_MASK_OFS = 16'h8144;  // event mask

  // control/status bit positions
  localparam int BUSY_BIT     = 0;
  localparam int LOCK_BIT     = 1;
  // self-clearing conditioner reset in output control
  localparam int COND_RST_BIT = 31;

  // fixed chip register address codes in bits 3-0
  localparam logic [3:0] OUTCTL_ADDR_CODE = 4'h0;
  localparam logic [3:0] FREQ_ADDR_CODE   = 4'hd;
  localparam logic [3:0] DIV_ADDR_CODE    = 4'he;

  // field positions of the frequency / loop filter word
  localparam int LF_CAP_LSB   = 4;   // loop_filter_cap_sel 7-4
  localparam int LF_RES_A_LSB = 8;   // loop_filter_res_a_sel 10-8
  localparam int LF_RES_B_LSB = 11;  // loop_filter_res_b_sel 13-11
  localparam int IN_MHZ_LSB   = 14;  // input_clock_mhz 21-14

  // field positions of the divider / lock word
  localparam int REF_DIV_LSB    = 8;   // reference divider 19-8
  localparam int LOCK_FUNC_LSB  = 20;  // lock_pin_function 23-20
  localparam int CHIP_SLEEP_BIT = 26;  // chip_sleep
  localparam int ALL_OUT_EN_BIT = 27;  // all_outputs_enable
  localparam int AUX_OUT_BIT    = 28;  // auxiliary output pin enable

  // power-up values
  localparam logic [31:0] FREQ_RESET   = 32'h0280000d;
  localparam logic [31:0] DIV_RESET    = 32'h08000a0e;
  localparam logic [31:0] OUTCTL_RESET = 32'h00000000;

  // interrupt status bits
  localparam int IRQ_W            = 3;
  localparam int IRQ_DONE_BIT     = 0;  // serial transfer finished
  localparam int IRQ_LOCK_LOST    = 1;  // lock detect fell
  localparam int IRQ_RST_DONE_BIT = 2;  // conditioner reset finished

  // timing
  localparam int CLK_PERIOD_NS    = 10;
  localparam int COND_RST_TIME_NS = 10000;
  localparam int COND_RST_CYCLES  =
    (COND_RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0] RST_WAIT_LAST = 10'(COND_RST_CYCLES - 1);
  // serial clock half period in system clocks
  localparam logic [1:0] SER_HALF      = 2'h2;
  localparam logic [1:0] SER_HALF_LAST = 2'h1;
  localparam logic [1:0] SER_FULL_LAST = 2'h3;
  localparam logic [4:0] SER_BITS_LAST = 5'h1f;

  // serial engine states
  typedef enum logic [1:0] {
    CCPSR_IDLE     = 2'b00,
    CCPSR_SHIFT    = 2'b01,
    CCPSR_LATCH    = 2'b10,
    CCPSR_RST_WAIT = 2'b11
  } ccpsr_state_t;

endpackage

// ---- src/ccpsr_top.sv ----
// shadow registers and serial programmer for an external pll clock chip
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
// How it works
// - board reset spares shadows; power-up clears all, bit31 clears freq and div
// - conditioner reset bit self-clears after 10 us
// - each shadow write shifts word to chip
// - busy bit 0 while serial transfer runs
// - frequency word bits 3-0 forced 1101
// - two resistor fields, reset to 000
// - divider word bits 3-0 forced 1110
// - live lock detect level on status bit 1
// - bit 26 sleeps whole chip until cleared
// - bit 27 global output enable, resets one
module ccpsr_top (
  // clock and resets
  input  wire logic                          CLK_IN,
  input  wire logic                          NRST_IN,
  input  wire logic                          NPOR_IN,
  // register port
  input  wire logic [ccpsr_pkg::ADDR_W-1:0]  ADDR_IN,
  input  wire logic [31:0]                   WDATA_IN,
  input  wire logic                          WR_IN,
  input  wire logic                          RD_IN,
  output logic      [31:0]                   RDATA_OUT,
  // interrupt
  output logic                               IRQ_OUT,
  // clock chip pins
  input  wire logic                          LOCK_DETECT_IN,
  output logic                               SER_CLK_OUT,
  output logic                               SER_DATA_OUT,
  output logic                               SER_LATCH_OUT
);
  import ccpsr_pkg::*;

  // shadow registers, cleared only by power-up; freq and div also by conditioner reset
  logic [31:0]  freq_reg, freq_next;      // frequency / loop filter
  logic [31:0]  div_reg, div_next;        // ref divider / lock / enables
  logic [31:0]  outctl_reg, outctl_next;  // output control

  // serial engine state
  ccpsr_state_t state_reg, state_next;
  logic [31:0]  shift_reg, shift_next;    // word on its way out
  logic [4:0]   bit_reg, bit_next;        // bits already sent
  logic [1:0]   phase_reg, phase_next;    // position in one bit
  logic [9:0]   wait_reg, wait_next;      // conditioner reset timer
  logic         rstp_reg, rstp_next;      // reset wait follows latch
  logic         sclk_reg, sclk_next;
  logic         sdat_reg, sdat_next;
  logic         latch_reg, latch_next;

  // lock detect synchroniser and edge history
  logic         lock_meta_reg;
  logic         lock_sync_reg;
  logic         lock_prev_reg;

  // interrupt state
  logic [IRQ_W-1:0] stat_reg, stat_next;
  logic [IRQ_W-1:0] mask_reg, mask_next;
  logic             irq_reg, irq_next;
  logic [IRQ_W-1:0] events;

  // read data
  logic [31:0]  rdata_reg, rdata_next;

  // decoded bus terms
  logic         busy;        // transfer or reset wait in progress
  logic         wr_ok;       // write accepted
  logic         wr_shadow;   // accepted write to a chip register
  logic         cond_rst;    // accepted write requesting chip reset
  logic         xfer_done;   // one-cycle end of a transfer
  logic         rst_done;    // one-cycle end of the reset wait
  logic [31:0]  load_word;   // word as stored and as shifted

  // busy covers shifting, latching and the reset wait
  assign busy = (state_reg != CCPSR_IDLE);
  // chip register writes while busy are dropped; software should poll first
  assign wr_ok = WR_IN && !busy;

  // address decode and forced address codes of the written word
  always_comb begin
    wr_shadow = 1'b0;
    cond_rst  = 1'b0;
    load_word = WDATA_IN;
    case (ADDR_IN)
      FREQ_OFS: begin
        wr_shadow      = wr_ok;
        load_word[3:0] = FREQ_ADDR_CODE;
      end
      DIV_OFS: begin
        wr_shadow      = wr_ok;
        load_word[3:0] = DIV_ADDR_CODE;
      end
      OUTCTL_OFS: begin
        wr_shadow      = wr_ok;
        cond_rst       = wr_ok && WDATA_IN[COND_RST_BIT];
        load_word[3:0] = OUTCTL_ADDR_CODE;
      end
      default: begin
        wr_shadow = 1'b0;
      end
    endcase
  end

  // next values of the shadow registers
  always_comb begin
    freq_next   = freq_reg;
    div_next    = div_reg;
    outctl_next = outctl_reg;
    if (cond_rst) begin
      freq_next   = FREQ_RESET;
      div_next    = DIV_RESET;
      outctl_next = load_word;
    end else if (wr_shadow) begin
      case (ADDR_IN)
        FREQ_OFS: freq_next   = load_word;
        DIV_OFS:  div_next    = load_word;
        default:  outctl_next = load_word;
      endcase
    end
    if (rst_done) begin
      outctl_next[COND_RST_BIT] = 1'b0;
    end
  end

  // shadows hang on the power-up reset, not the board reset
  // power-up reset only
  always_ff @(posedge CLK_IN or negedge NPOR_IN) begin
    if (!NPOR_IN) begin
      freq_reg   <= FREQ_RESET;
      div_reg    <= DIV_RESET;
      outctl_reg <= OUTCTL_RESET;
    end else begin
      freq_reg   <= freq_next;
      div_reg    <= div_next;
      outctl_reg <= outctl_next;
    end
  end

  // serial engine: msb first, data steady while clock high, then latch
  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    bit_next   = bit_reg;
    phase_next = phase_reg;
    wait_next  = wait_reg;
    rstp_next  = rstp_reg;
    sclk_next  = sclk_reg;
    sdat_next  = sdat_reg;
    latch_next = 1'b0;
    xfer_done  = 1'b0;
    rst_done   = 1'b0;
    case (state_reg)
      CCPSR_IDLE: begin
        sclk_next = 1'b0;
        sdat_next = 1'b0;
        if (wr_shadow) begin
          state_next = CCPSR_SHIFT;
          shift_next = load_word;
          sdat_next  = load_word[31];
          bit_next   = 5'h00;
          phase_next = 2'h0;
          rstp_next  = cond_rst;
        end
      end
      CCPSR_SHIFT: begin
        phase_next = phase_reg + 2'h1;
        // rising serial clock at mid-bit
        if (phase_reg == SER_HALF_LAST) begin
          sclk_next = 1'b1;
        end
        // falling edge: advance to the next bit or finish
        if (phase_reg == SER_FULL_LAST) begin
          sclk_next  = 1'b0;
          phase_next = 2'h0;
          shift_next = {shift_reg[30:0], 1'b0};
          sdat_next  = shift_reg[30];
          bit_next   = bit_reg + 5'h01;
          if (bit_reg == SER_BITS_LAST) begin
            state_next = CCPSR_LATCH;
            sdat_next  = 1'b0;
            latch_next = 1'b1;
          end
        end
      end
      CCPSR_LATCH: begin
        // latch pulse lasts one serial half period
        phase_next = phase_reg + 2'h1;
        latch_next = 1'b1;
        if (phase_reg == SER_HALF_LAST) begin
          latch_next = 1'b0;
          phase_next = 2'h0;
          if (rstp_reg) begin
            state_next = CCPSR_RST_WAIT;
            wait_next  = 10'h000;
          end else begin
            state_next = CCPSR_IDLE;
            xfer_done  = 1'b1;
          end
        end
      end
      CCPSR_RST_WAIT: begin
        wait_next = wait_reg + 10'h001;
        if (wait_reg == RST_WAIT_LAST) begin
          state_next = CCPSR_IDLE;
          rstp_next  = 1'b0;
          xfer_done  = 1'b1;
          rst_done   = 1'b1;
        end
      end
      default: begin
        state_next = CCPSR_IDLE;
      end
    endcase
  end

  // serial engine registers
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      state_reg <= CCPSR_IDLE;
      shift_reg <= 32'h00000000;
      bit_reg   <= 5'h00;
      phase_reg <= 2'h0;
      wait_reg  <= 10'h000;
      rstp_reg  <= 1'b0;
      sclk_reg  <= 1'b0;
      sdat_reg  <= 1'b0;
      latch_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      bit_reg   <= bit_next;
      phase_reg <= phase_next;
      wait_reg  <= wait_next;
      rstp_reg  <= rstp_next;
      sclk_reg  <= sclk_next;
      sdat_reg  <= sdat_next;
      latch_reg <= latch_next;
    end
  end

  // two-stage synchroniser, edge history reads only the second stage
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      lock_meta_reg <= 1'b0;
      lock_sync_reg <= 1'b0;
      lock_prev_reg <= 1'b0;
    end else begin
      lock_meta_reg <= LOCK_DETECT_IN;
      lock_sync_reg <= lock_meta_reg;
      lock_prev_reg <= lock_sync_reg;
    end
  end

  // event sources and sticky status, set beats write-one-to-clear
  always_comb begin
    events                   = '0;
    events[IRQ_DONE_BIT]     = xfer_done;
    events[IRQ_LOCK_LOST]    = lock_prev_reg && !lock_sync_reg;
    events[IRQ_RST_DONE_BIT] = rst_done;
    stat_next = stat_reg;
    mask_next = mask_reg;
    if (WR_IN && ADDR_IN == IRQ_STAT_OFS) begin
      stat_next = stat_reg & ~WDATA_IN[IRQ_W-1:0];
    end
    if (WR_IN && ADDR_IN == IRQ_MASK_OFS) begin
      mask_next = WDATA_IN[IRQ_W-1:0];
    end
    stat_next = stat_next | events;
    irq_next  = |(stat_next & mask_next);
  end

  // interrupt registers
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      stat_reg <= '0;
      mask_reg <= '0;
      irq_reg  <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      irq_reg  <= irq_next;
    end
  end

  // read mux; data stands one cycle after the strobe, zero otherwise
  always_comb begin
    rdata_next = 32'h00000000;
    if (RD_IN) begin
      case (ADDR_IN)
        CSR_OFS: begin
          rdata_next[BUSY_BIT] = busy;
          rdata_next[LOCK_BIT] = lock_sync_reg;
        end
        OUTCTL_OFS:   rdata_next = outctl_reg;
        FREQ_OFS:     rdata_next = freq_reg;
        DIV_OFS:      rdata_next = div_reg;
        IRQ_STAT_OFS: rdata_next[IRQ_W-1:0] = stat_reg;
        IRQ_MASK_OFS: rdata_next[IRQ_W-1:0] = mask_reg;
        // unmapped reads return zero
        default:      rdata_next = 32'h00000000;
      endcase
    end
  end

  // read data register
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rdata_reg <= 32'h00000000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // outputs straight from flops
  assign RDATA_OUT     = rdata_reg;
  assign IRQ_OUT       = irq_reg;
  assign SER_CLK_OUT   = sclk_reg;
  assign SER_DATA_OUT  = sdat_reg;
  assign SER_LATCH_OUT = latch_reg;
endmodule // ccpsr_top

// ---- tb/ccpsr_top_assertions.sv ----
// port assertions for the pll shadow register block
`timescale 1ns/1ps
module ccpsr_top_assertions (
  // clock and resets
  input wire logic        CLK_IN,
  input wire logic        NRST_IN,
  input wire logic        NPOR_IN,
  // register port
  input wire logic [ccpsr_pkg::ADDR_W-1:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic        WR_IN,
  input wire logic        RD_IN,
  input wire logic [31:0] RDATA_OUT,
  // interrupt and chip pins
  input wire logic        IRQ_OUT,
  input wire logic        LOCK_DETECT_IN,
  input wire logic        SER_CLK_OUT,
  input wire logic        SER_DATA_OUT,
  input wire logic        SER_LATCH_OUT
);
  import ccpsr_pkg::*;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!NRST_IN);
  logic [1:0] hist_reg;  // last two lock samples
  logic [1:0] hist_next;
  // lock history, so a read only checks a settled pin
  always_comb begin
    hist_next = {hist_reg[0], LOCK_DETECT_IN};
  end
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      hist_reg <= 2'h0;
    end else begin
      hist_reg <= hist_next;
    end
  end
  a_rdata_idle_zero: assert property (!$past(RD_IN) |-> RDATA_OUT == 0)
    else $error("read data not zero outside read");
  a_unmapped_zero: assert property (RD_IN && ADDR_IN == 16'h0 |=> RDATA_OUT == 0)
    else $error("unmapped read not zero");
  a_freq_code: assert property (RD_IN && ADDR_IN == FREQ_OFS
    |=> RDATA_OUT[3:0] == FREQ_ADDR_CODE) else $error("freq code wrong");
  a_div_code: assert property (RD_IN && ADDR_IN == DIV_OFS
    |=> RDATA_OUT[3:0] == DIV_ADDR_CODE) else $error("div code wrong");
  a_lock_level: assert property (RD_IN && ADDR_IN == CSR_OFS &&
    hist_reg == {2{LOCK_DETECT_IN}} |=> RDATA_OUT[LOCK_BIT] ==
    $past(LOCK_DETECT_IN)) else $error("lock bit not live level");
  a_data_stable: assert property (SER_CLK_OUT |-> $stable(SER_DATA_OUT))
    else $error("serial data moved while clock high");
  a_clk_high_two: assert property ($rose(SER_CLK_OUT)
    |=> SER_CLK_OUT ##1 !SER_CLK_OUT) else $error("serial clock width");
  a_latch_two: assert property ($rose(SER_LATCH_OUT) |->
    !SER_CLK_OUT ##1 SER_LATCH_OUT ##1 !SER_LATCH_OUT)
    else $error("latch width wrong");
  a_mask_quiet: assert property (WR_IN && ADDR_IN == IRQ_MASK_OFS &&
    WDATA_IN[IRQ_W-1:0] == 0 ##1 !WR_IN |=> !IRQ_OUT)
    else $error("irq high with all masked");
endmodule // ccpsr_top_assertions

bind ccpsr_top ccpsr_top_assertions u_ccpsr_top_assertions (
  .CLK_IN(CLK_IN), .NRST_IN(NRST_IN), .NPOR_IN(NPOR_IN),
  .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
  .RDATA_OUT(RDATA_OUT), .IRQ_OUT(IRQ_OUT),
  .LOCK_DETECT_IN(LOCK_DETECT_IN), .SER_CLK_OUT(SER_CLK_OUT),
  .SER_DATA_OUT(SER_DATA_OUT), .SER_LATCH_OUT(SER_LATCH_OUT));

// ---- tb/ccpsr_chip_model.sv ----
// behavioural model of the external pll clock chip
`timescale 1ns/1ps
module ccpsr_chip_model (
  // serial programming pins
  input  wire logic ser_clk_in,
  input  wire logic ser_data_in,
  input  wire logic ser_latch_in,
  // lock pin and captured words
  output logic        lock_out,
  output logic [31:0] freq_out,
  output logic [31:0] div_out
);
  logic [31:0] sh;  // bits in flight, msb first
  // chip power-up contents
  initial begin
    sh = 32'h0;
    freq_out = 32'h0280000d;
    div_out = 32'h08000a0e;
  end
  // bits enter on the rising clock
  always @(posedge ser_clk_in) begin
    sh <= {sh[30:0], ser_data_in};
  end
  always @(posedge ser_latch_in) begin
    case (sh[3:0])
      4'hd: freq_out <= sh;
      4'he: div_out <= sh;
      4'h0: begin
        if (sh[31]) begin
          freq_out <= 32'h0280000d;
          div_out <= 32'h08000a0e;
        end
      end
      default: begin
      end
    endcase
  end
  always_comb begin
    lock_out = (div_out[23:20] == 4'h3) && !div_out[26];
  end
endmodule // ccpsr_chip_model

// ---- tb/test_clock_chip_pll_shadow_regs.sv ----
// self-checking bench for the pll shadow register block
`timescale 1ns/1ps
module test_clock_chip_pll_shadow_regs;
  import ccpsr_pkg::*;
  logic clk, nrst, npor, wr, rd, irq, lk, sc, sd, sl;
  logic [15:0] addr;
  logic [31:0] wdata, rdata, fw_chip, dw_chip, v;
  int n_errors, checks, n;
  // recommended words with zero address bits
  // recommended capacitor 0101
  localparam logic [31:0] FW = {10'h00a, 8'h64, 6'h0, 4'h5, 4'h0};
  localparam logic [31:0] DW = {5'h1, 3'h0, 4'h3, 12'h001, 8'h0};
  localparam logic [31:0] FDEF = {10'h00a, 18'h0, 4'hd};
  localparam logic [31:0] DDEF = {4'h0, 1'b1, 7'h0, 12'h00a, 8'he};
  ccpsr_top u_ccpsr_top (.CLK_IN(clk), .NRST_IN(nrst), .NPOR_IN(npor),
    .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
    .RDATA_OUT(rdata), .IRQ_OUT(irq), .LOCK_DETECT_IN(lk),
    .SER_CLK_OUT(sc), .SER_DATA_OUT(sd), .SER_LATCH_OUT(sl));
  ccpsr_chip_model u_ccpsr_chip_model (.ser_clk_in(sc),
    .ser_data_in(sd), .ser_latch_in(sl), .lock_out(lk),
    .freq_out(fw_chip), .div_out(dw_chip));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic wr32(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task automatic rd32(input logic [15:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [15:0] a, input logic [31:0] exp);
    rd32(a);
    chk(v, exp);
  endtask
  // poll busy, bounded; n counts the polls
  // wait busy low before writing
  task automatic wait_idle;
    n = 0;
    v = 32'h1;
    while (v[BUSY_BIT] && n < 1000) begin
      rd32(CSR_OFS);
      n++;
    end
    chk(32'(v[BUSY_BIT]), 32'h0);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // watchdog: whole run needs about 1700 cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("mismatch at %0t: run hung", $time);
    end_sim;
  end
  initial begin
    {nrst, npor, wr, rd, addr, wdata} = '0;
    n_errors = 0;
    checks = 0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    npor <= 1'b1;
    rchk(FREQ_OFS, FDEF);
    rchk(DIV_OFS, DDEF);
    rchk(16'h0000, 32'h0);
    $display("power-up test done");
    // write, busy seen, second write refused while busy
    wr32(FREQ_OFS, FW);
    rd32(CSR_OFS);
    chk(v & 32'h1, 32'h1);
    wr32(FREQ_OFS, 32'hffffffff);
    wait_idle;
    rchk(FREQ_OFS, FW | 32'hd);
    chk(fw_chip, FW | 32'hd);
    rchk(IRQ_STAT_OFS, 32'h1);
    wr32(IRQ_MASK_OFS, 32'h1);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h1);
    wr32(IRQ_MASK_OFS, 32'h0);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    wr32(IRQ_STAT_OFS, 32'h1);
    $display("frequency write test done");
    // lock detect follows the chip, then sleep drops it
    wr32(DIV_OFS, DW);
    wait_idle;
    chk(dw_chip, DW | 32'he);
    rd32(CSR_OFS);
    chk(v & 32'h2, 32'h2);
    wr32(DIV_OFS, DW | 32'h04000000);
    wait_idle;
    rd32(CSR_OFS);
    chk(v & 32'h2, 32'h0);
    rchk(IRQ_STAT_OFS, 32'h3);
    wr32(IRQ_MASK_OFS, 32'h2);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h1);
    wr32(IRQ_STAT_OFS, 32'h7);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    $display("lock test done");
    // board reset keeps the shadows
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rchk(FREQ_OFS, FW | 32'hd);
    rchk(DIV_OFS, DW | 32'h0400000e);
    $display("board reset test done");
    // conditioner reset request clears shadows and itself
    wr32(OUTCTL_OFS, 32'h80000000);
    wait_idle;
    chk(32'(n >= 560), 32'h1);
    rchk(OUTCTL_OFS, 32'h0);
    rchk(FREQ_OFS, FDEF);
    rchk(DIV_OFS, DDEF);
    chk(fw_chip, FDEF);
    rchk(IRQ_STAT_OFS, 32'h5);
    // plain output control write keeps its word, code bits forced zero
    wr32(OUTCTL_OFS, 32'h0000012f);
    wait_idle;
    rchk(OUTCTL_OFS, 32'h00000120);
    $display("conditioner reset test done");
    end_sim;
  end
endmodule // test_clock_chip_pll_shadow_regs
